// [shared/calq_pkg.sv]
// Constants, address map and carriers for the calibration status register tree.
// Assumes a 32-bit APB slave port and one clock; no timing constants are needed.
package calq_pkg;

  // ****************************************************************
  // Tree shape
  // ****************************************************************
  localparam int DATA_W = 32;
  localparam int FLD_W = 15;
  localparam int NUM_CH = 4;
  localparam int KINDS_PER_CH = 4;
  localparam int NUM_LEAF = NUM_CH * KINDS_PER_CH;
  localparam int CAL_NODE = 0;
  localparam int CH_NODE_BASE = 1;
  localparam int LEAF_NODE_BASE = CH_NODE_BASE + NUM_CH;
  localparam int NUM_NODES = LEAF_NODE_BASE + NUM_LEAF;

  // Leaf order inside one channel, which is also the parent's condition bit
  localparam int KIND_AD = 0;
  localparam int KIND_DELAY = 1;
  localparam int KIND_GAIN = 2;
  localparam int KIND_HYST = 3;

  typedef logic [FLD_W-1:0] field_t;

  // ****************************************************************
  // Reset and preset values
  // ****************************************************************
  // Bit 15 is reserved and never stored, so it always reads zero
  localparam field_t MASK_RST = 15'h0000;
  localparam field_t PRESET_MASK = 15'h7fff;
  localparam field_t FIELD_ZERO = 15'h0000;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int AREA_LSB = 10;
  localparam int AREA_W = 2;
  localparam int NODE_LSB = 4;
  localparam int NODE_W = 6;
  localparam int SEL_LSB = 2;
  localparam int SEL_W = 2;

  localparam logic [1:0] AREA_NODE = 2'h0;
  localparam logic [1:0] AREA_CTRL = 2'h1;
  localparam logic [1:0] SEL_COND = 2'h0;
  localparam logic [1:0] SEL_EVENT = 2'h1;
  localparam logic [1:0] SEL_ENABLE = 2'h2;
  localparam logic [1:0] CTRL_PRESET = 2'h0;
  localparam logic [1:0] CTRL_IRQ_STATUS = 2'h1;
  localparam logic [1:0] CTRL_IRQ_MASK = 2'h2;

  // ****************************************************************
  // Control fields
  // ****************************************************************
  localparam int PRESET_BIT = 0;
  localparam int IRQ_W = 2;
  localparam int IRQ_SUM_RISE = 0;
  localparam int IRQ_BAD_ADDR = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    field_t ev;
    field_t mask;
  } node_view_s;

  typedef struct packed {
    logic mask_we;
    logic preset;
    field_t wdata;
    field_t ev_clr;
  } node_ctl_s;

endpackage : calq_pkg

// [src/status_node.sv]
// One status node: live condition, latched rising-edge events, enable mask.
// Assumes the condition input is synchronous to clk and that clears name only reported bits.
`timescale 1ns/10ps

module status_node (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Live condition and control
  input wire calq_pkg::field_t cond,
  input wire calq_pkg::node_ctl_s ctl,
  // Stored state and summary
  output calq_pkg::node_view_s view,
  output logic summary
);

  typedef struct packed {
    calq_pkg::field_t prev;
    calq_pkg::field_t ev;
    calq_pkg::field_t mask;
  } node_state_s;

  node_state_s st;
  node_state_s next_st;

  always_comb begin
    next_st = st;
    next_st.prev = cond;
    // A rise in the clearing cycle survives: set is ORed after the clear
    next_st.ev = (st.ev & ~ctl.ev_clr) | (cond & ~st.prev); // RULE_05 RULE_06
    if (ctl.preset) begin
      next_st.mask = calq_pkg::PRESET_MASK; // RULE_14
    end else if (ctl.mask_we) begin
      next_st.mask = ctl.wdata; // RULE_03
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '{prev: calq_pkg::FIELD_ZERO, ev: calq_pkg::FIELD_ZERO, mask: calq_pkg::MASK_RST};
    end else begin
      st <= next_st;
    end
  end

  assign view = '{ev: st.ev, mask: st.mask}; // RULE_01
  assign summary = |(st.ev & st.mask); // RULE_15 RULE_03

endmodule : status_node

// [src/calib_status_regs.sv]
// Calibration branch of the questionable status tree behind an APB slave.
// Assumes leaf conditions arrive synchronous to CLK; the APB master follows APB3 signalling.
`timescale 1ns/10ps

// What this block does
// RULE_01: Each node has condition, event, enable registers.
// RULE_02: Condition read returns live status bits.
// RULE_03: Enable write loads mask gating upward summary.
// RULE_04: Enable read returns mask, leaves it unchanged.
// RULE_05: Events latch only rising condition edges.
// RULE_06: Event read returns bits and clears them.
// RULE_07: Calibration summary node feeds questionable register.
// RULE_08: One summary node per channel, four channels.
// RULE_09: Per-channel A/D node feeds channel node.
// RULE_10: Per-channel delay node feeds channel node.
// RULE_11: Per-channel gain node feeds channel node.
// RULE_12: Per-channel hysteresis node feeds channel node.
// RULE_13: Bits 0-14 weigh 1..16384, bit 15 reserved.
// RULE_14: Preset sets all enables, events untouched.
// RULE_15: Parent condition bit is OR of child's masked events.
module calib_status_regs (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [calq_pkg::ADDR_W-1:0] PADDR,
  input wire logic [calq_pkg::DATA_W-1:0] PWDATA,
  output logic PREADY,
  output logic [calq_pkg::DATA_W-1:0] PRDATA,
  output logic PSLVERR,
  // Live calibration status of every leaf, channel-major, A/D first
  input wire calq_pkg::field_t [calq_pkg::NUM_LEAF-1:0] LEAF_COND,
  // Upward summary and interrupt
  output logic QUES_CAL_SUMMARY,
  output logic IRQ
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [calq_pkg::DATA_W-1:0] rdata;
    logic err;
    logic [calq_pkg::IRQ_W-1:0] irq_status;
    logic [calq_pkg::IRQ_W-1:0] irq_mask;
    logic sum_prev;
  } top_state_s;

  top_state_s st;
  top_state_s next_st;

  calq_pkg::field_t [calq_pkg::NUM_NODES-1:0] node_cond;
  calq_pkg::node_view_s [calq_pkg::NUM_NODES-1:0] node_view;
  calq_pkg::node_ctl_s [calq_pkg::NUM_NODES-1:0] node_ctl;
  logic [calq_pkg::NUM_NODES-1:0] node_sum;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [calq_pkg::AREA_W-1:0] area;
  logic [calq_pkg::NODE_W-1:0] node_idx;
  logic [calq_pkg::SEL_W-1:0] sel;
  logic node_hit;
  logic ctrl_hit;
  logic addr_ok;
  logic setup;
  logic access;
  logic wr_access;
  logic rd_access;

  assign area = PADDR[calq_pkg::AREA_LSB +: calq_pkg::AREA_W];
  assign node_idx = PADDR[calq_pkg::NODE_LSB +: calq_pkg::NODE_W];
  assign sel = PADDR[calq_pkg::SEL_LSB +: calq_pkg::SEL_W];

  // Each node owns a 16-byte slot; the fourth word of a slot is unmapped
  assign node_hit = (area == calq_pkg::AREA_NODE) && (int'(node_idx) < calq_pkg::NUM_NODES)
                    && (sel != 2'h3);
  // Control words share slot zero of their area
  assign ctrl_hit = (area == calq_pkg::AREA_CTRL) && (node_idx == '0) && (sel != 2'h3);
  assign addr_ok = node_hit || ctrl_hit;

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  // Zero wait states; an errored access changes no register but the IRQ_BAD_ADDR status bit
  assign wr_access = access && PWRITE && !st.err;
  assign rd_access = access && !PWRITE && !st.err;

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  function automatic logic [calq_pkg::DATA_W-1:0] zext(input calq_pkg::field_t f);
    zext = {{(calq_pkg::DATA_W - calq_pkg::FLD_W){1'b0}}, f}; // RULE_13
  endfunction : zext

  logic [calq_pkg::DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = calq_pkg::RDATA_RST;
    if (node_hit) begin
      unique case (sel)
        calq_pkg::SEL_COND: rd_mux = zext(node_cond[node_idx]); // RULE_02
        calq_pkg::SEL_EVENT: rd_mux = zext(node_view[node_idx].ev); // RULE_06
        calq_pkg::SEL_ENABLE: rd_mux = zext(node_view[node_idx].mask); // RULE_04
        default: rd_mux = calq_pkg::RDATA_RST;
      endcase
    end else if (ctrl_hit) begin
      unique case (sel)
        calq_pkg::CTRL_IRQ_STATUS: rd_mux = {{(calq_pkg::DATA_W - calq_pkg::IRQ_W){1'b0}}, st.irq_status};
        calq_pkg::CTRL_IRQ_MASK: rd_mux = {{(calq_pkg::DATA_W - calq_pkg::IRQ_W){1'b0}}, st.irq_mask};
        // Preset is a strobe, nothing to read back
        default: rd_mux = calq_pkg::RDATA_RST;
      endcase
    end
  end

  // ****************************************************************
  // Node control strobes
  // ****************************************************************
  logic preset_wr;

  assign preset_wr = wr_access && ctrl_hit && (sel == calq_pkg::CTRL_PRESET)
                     && PWDATA[calq_pkg::PRESET_BIT];

  always_comb begin
    for (int n = 0; n < calq_pkg::NUM_NODES; n++) begin
      node_ctl[n].preset = preset_wr; // RULE_14
      node_ctl[n].wdata = PWDATA[calq_pkg::FLD_W-1:0]; // RULE_13
      node_ctl[n].mask_we = wr_access && node_hit && (int'(node_idx) == n)
                            && (sel == calq_pkg::SEL_ENABLE); // RULE_03
      // Clear exactly what the read returned, so a bit that rose after the
      // data was captured in the setup cycle is reported next time
      node_ctl[n].ev_clr = (rd_access && node_hit && (int'(node_idx) == n)
                            && (sel == calq_pkg::SEL_EVENT))
                           ? st.rdata[calq_pkg::FLD_W-1:0] : calq_pkg::FIELD_ZERO; // RULE_06
    end
  end

  // ****************************************************************
  // Node tree
  // ****************************************************************
  for (genvar n = 0; n < calq_pkg::NUM_NODES; n++) begin : g_node
    if (n >= calq_pkg::LEAF_NODE_BASE) begin : g_leaf
      // Leaves take live calibration status from the channel hardware
      assign node_cond[n] = LEAF_COND[n - calq_pkg::LEAF_NODE_BASE]; // RULE_09 RULE_10 RULE_11 RULE_12
    end else if (n >= calq_pkg::CH_NODE_BASE) begin : g_chan
      // Bits follow leaf kind: A/D, delay, gain, hysteresis
      assign node_cond[n] = calq_pkg::field_t'(node_sum[calq_pkg::LEAF_NODE_BASE
                            + (n - calq_pkg::CH_NODE_BASE) * calq_pkg::KINDS_PER_CH
                            +: calq_pkg::KINDS_PER_CH]); // RULE_08 RULE_15
    end else begin : g_cal
      // Bit c summarises channel c, whose summary node is c+1
      assign node_cond[n] = calq_pkg::field_t'(node_sum[calq_pkg::CH_NODE_BASE
                            +: calq_pkg::NUM_CH]); // RULE_07 RULE_15
    end

    status_node u_node (
      .clk(CLK),
      .rst_b(RST_B),
      .cond(node_cond[n]),
      .ctl(node_ctl[n]),
      .view(node_view[n]),
      .summary(node_sum[n])
    ); // RULE_01
  end

  // ****************************************************************
  // Register update
  // ****************************************************************
  logic sum_rise;
  logic bad_access;
  logic [calq_pkg::IRQ_W-1:0] irq_set;
  logic [calq_pkg::IRQ_W-1:0] irq_clr;

  assign sum_rise = node_sum[calq_pkg::CAL_NODE] && !st.sum_prev;
  assign bad_access = access && st.err;

  always_comb begin
    irq_set = '0;
    irq_set[calq_pkg::IRQ_SUM_RISE] = sum_rise;
    irq_set[calq_pkg::IRQ_BAD_ADDR] = bad_access;
    irq_clr = (wr_access && ctrl_hit && (sel == calq_pkg::CTRL_IRQ_STATUS))
              ? PWDATA[calq_pkg::IRQ_W-1:0] : '0;
  end

  always_comb begin
    next_st = st;
    next_st.sum_prev = node_sum[calq_pkg::CAL_NODE];
    // Read data and error are captured in the setup cycle and held through access
    if (setup) begin
      next_st.rdata = PWRITE ? calq_pkg::RDATA_RST : rd_mux;
      next_st.err = !addr_ok;
    end
    // Write-one-to-clear; a new event in the same cycle stays set
    next_st.irq_status = (st.irq_status & ~irq_clr) | irq_set;
    if (wr_access && ctrl_hit && (sel == calq_pkg::CTRL_IRQ_MASK)) begin
      next_st.irq_mask = PWDATA[calq_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st <= '{rdata: calq_pkg::RDATA_RST, err: 1'b0, irq_status: calq_pkg::IRQ_RST,
              irq_mask: calq_pkg::IRQ_RST, sum_prev: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign PREADY = access;
  assign PRDATA = st.rdata;
  assign PSLVERR = access && st.err;
  assign QUES_CAL_SUMMARY = node_sum[calq_pkg::CAL_NODE]; // RULE_07
  assign IRQ = |(st.irq_status & st.irq_mask);

endmodule : calib_status_regs

// [sim/calq_host.sv]
// Host model: the software side issuing status queries over APB.
// Assumes one clock; every transfer is one setup and one access phase.
`timescale 1ns/10ps

module calq_host (
  // Clock
  input wire logic clk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [calq_pkg::ADDR_W-1:0] paddr,
  output logic [calq_pkg::DATA_W-1:0] pwdata,
  input wire logic pready,
  input wire logic [calq_pkg::DATA_W-1:0] prdata,
  input wire logic pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end

  // Request held until pready is seen high at a rising edge; no latency assumed
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : xfer
endmodule : calq_host

// [sim/calq_chk.sv]
// Port checker for the calibration status tree.
// Assumes it is bound to calib_status_regs and sees only its ports.
`timescale 1ns/10ps

module calq_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [calq_pkg::ADDR_W-1:0] PADDR,
  input wire logic PREADY,
  input wire logic [calq_pkg::DATA_W-1:0] PRDATA,
  input wire logic PSLVERR,
  // Tree
  input wire calq_pkg::field_t [calq_pkg::NUM_LEAF-1:0] LEAF_COND,
  input wire logic QUES_CAL_SUMMARY,
  input wire logic IRQ
);
  wire logic acc = PSEL && PENABLE;
  wire logic [5:0] nd = PADDR[9:4];
  wire logic [3:0] li = 4'(nd - 6'h05);
  wire logic in0 = PADDR[11:10] == 2'h0;
  wire logic lcond = in0 && PADDR[3:2] == 2'h0 && nd >= 6'h05 && nd <= 6'h14;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_zero_wait: assert property (acc |-> PREADY)
    else $error("no ready in access");
  a_rsvd_zero: assert property (acc && !PWRITE |-> PRDATA[31:15] == 17'h0)
    else $error("upper read bits set");
  a_cond_read: assert property (acc && !PWRITE && lcond |-> PRDATA[14:0] == $past(LEAF_COND[li]))
    else $error("condition read not live");
  a_bad_addr: assert property (acc && PADDR == 12'h40c |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_good_addr: assert property (acc && in0 && PADDR[3:2] != 2'h3 && nd <= 6'h14 |-> !PSLVERR)
    else $error("mapped access refused");
  a_reset_quiet: assert property ($rose(RST_B) |-> PRDATA == 32'h0 && !IRQ && !QUES_CAL_SUMMARY)
    else $error("outputs live after reset");
  a_rdata_hold: assert property (acc |=> PRDATA == $past(PRDATA))
    else $error("read data moved after access");
  a_sum_sticky: assert property ($fell(QUES_CAL_SUMMARY) && $past(RST_B) |-> $past(acc))
    else $error("summary fell without access");
  a_irq_sticky: assert property ($fell(IRQ) && $past(RST_B) |-> $past(acc && PWRITE))
    else $error("irq fell without write");

  c_refused: cover property (acc && PSLVERR);
  c_summary: cover property ($rose(QUES_CAL_SUMMARY));
  c_irq: cover property ($rose(IRQ));
endmodule : calq_chk

bind calib_status_regs calq_chk u_chk (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .LEAF_COND(LEAF_COND), .QUES_CAL_SUMMARY(QUES_CAL_SUMMARY), .IRQ(IRQ));

// [sim/tb_calib_status_regs.sv]
// Testbench for the calibration status tree behind APB.
// Assumes calq_host drives the bus and calq_chk is bound to the design.
`timescale 1ns/10ps

module tb_calib_status_regs;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, QUES_CAL_SUMMARY, IRQ, e;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  calq_pkg::field_t [calq_pkg::NUM_LEAF-1:0] LEAF_COND = '0;
  int err_count = 0;
  int check_count = 0;

  always #50 CLK = ~CLK;

  calib_status_regs uut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .LEAF_COND(LEAF_COND), .QUES_CAL_SUMMARY(QUES_CAL_SUMMARY), .IRQ(IRQ));
  calq_host host (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
    .pwdata(PWDATA), .pready(PREADY), .prdata(PRDATA), .pslverr(PSLVERR));

  // ****************************************************************
  // Access and compare helpers
  // ****************************************************************
  task chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      err_count++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask : chk

  task rd(input logic [11:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask : rd

  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask : wr

  // Node n, register select s: condition 0, event 1, enable 2
  function automatic logic [11:0] na(input int n, input int s);
    return 12'(n * 16 + s * 4);
  endfunction : na

  task stop_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
    for (int n = 0; n < 21; n++) begin
      rd(na(n, 2), 32'h0);
      rd(na(n, 1), 32'h0);
    end
    wr(na(5, 2), 32'hffff_ffff);
    rd(na(5, 2), 32'h7fff);
    rd(na(5, 2), 32'h7fff);
    @(posedge CLK);
    LEAF_COND[0] <= 15'h4005;
    @(posedge CLK);
    // Bits 0, 2 and 14 fall here, so only rises may add to the event
    LEAF_COND[0] <= 15'h000a;
    rd(na(5, 0), 32'h000a);
    rd(na(1, 0), 32'h1);
    // Channel masks are still clear, so nothing may reach the top yet
    rd(na(0, 0), 32'h0);
    wr(12'h400, 32'h1);
    rd(na(0, 2), 32'h7fff);
    rd(na(5, 1), 32'h400f);
    rd(na(5, 1), 32'h0);
    rd(na(1, 1), 32'h1);
    rd(na(0, 1), 32'h1);
    // Walk every channel and kind up to the top summary and clear it again
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge CLK);
        LEAF_COND[c * 4 + k] <= 15'h0100;
        repeat (6) @(posedge CLK);
        rd(na(1 + c, 0), 32'(1 << k));
        rd(na(0, 0), 32'(1 << c));
        LEAF_COND[c * 4 + k] <= 15'h0;
        #1 chk(32'(QUES_CAL_SUMMARY), 32'h1);
        rd(na(5 + c * 4 + k, 1), 32'h0100);
        rd(na(1 + c, 1), 32'(1 << k));
        rd(na(0, 1), 32'(1 << c));
        #1 chk(32'(QUES_CAL_SUMMARY), 32'h0);
      end
    end
    wr(12'h408, 32'h2);
    #1 chk(32'(IRQ), 32'h0);
    rd(12'h40c, 32'h0);
    chk(32'(e), 32'h1);
    #1 chk(32'(IRQ), 32'h1);
    rd(12'h404, 32'h3);
    wr(12'h404, 32'h3);
    #1 chk(32'(IRQ), 32'h0);
    // A new rise at a leaf must climb the tree and raise the summary interrupt
    wr(12'h408, 32'h1);
    LEAF_COND[0] <= 15'h0001;
    repeat (6) @(posedge CLK);
    #1 chk(32'(IRQ), 32'h1);
    rd(12'h404, 32'h1);
    stop_test;
  end

  // Whole run is near 550 cycles; nine times that means a hang
  initial begin
    repeat (5000) @(posedge CLK);
    err_count++;
    stop_test;
  end
endmodule : tb_calib_status_regs
